// ===== bench/uhcc_command_chk.sv
// Checker bound to the USB command register block ports
module uhcc_chk
    import uhcc_pkg::*;
(
    input wire logic              mclk,
    input wire logic              rst_b,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              reg_rvalid,
    input wire logic              async_evict_done,
    input wire logic              async_advance_int_en,
    input wire logic              int_threshold_tick,
    input wire logic              async_advance_flag_clr,
    input wire logic              run_stop,
    input wire logic              halted_flag,
    input wire logic              async_evict_req,
    input wire logic              async_advance_flag,
    input wire logic              async_advance_irq,
    input wire logic              ctrl_reset_active,
    input wire logic              txn_abort,
    input wire logic              port_owner_revert
);
    logic [7:0] len_reg;
    logic [7:0] len_next;
    // Counts reset cycles so the exact duration can be checked up to 255
    always_comb len_next = ctrl_reset_active ? len_reg + 8'h01 : 8'h00;
    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b) len_reg <= 8'h00;
        else len_reg <= len_next;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    property p_rd_ans; reg_rd |=> reg_rvalid && reg_rdata[31:7] == 25'h0; endproperty
    property p_rd_rst;
        reg_rvalid && $past(reg_addr) == USB_COMMAND_OFS |->
            reg_rdata[1] == $past(ctrl_reset_active);
    endproperty
    property p_evict;
        async_evict_req && async_evict_done |=> async_advance_flag && !async_evict_req;
    endproperty
    property p_flag_src; $rose(async_advance_flag) |-> $past(async_evict_req); endproperty
    property p_irq_set;
        int_threshold_tick && async_advance_flag && async_advance_int_en &&
            !async_advance_flag_clr |=> async_advance_irq;
    endproperty
    property p_irq_src;
        $rose(async_advance_irq) |-> $past(int_threshold_tick && async_advance_int_en);
    endproperty
    property p_irq_fall; !async_advance_flag |-> !async_advance_irq; endproperty
    property p_rst_start;
        $rose(ctrl_reset_active) |-> txn_abort && port_owner_revert ##1 !txn_abort;
    endproperty
    property p_rst_clr;
        $rose(ctrl_reset_active) |-> !run_stop && halted_flag && !async_advance_flag;
    endproperty
    property p_rst_len; $fell(ctrl_reset_active) |-> len_reg == 8'(RESET_CYCLES); endproperty
    property p_run; run_stop |=> !halted_flag || ctrl_reset_active; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer wrong");
    a_rd_rst: assert property (p_rd_rst) else $error("reset bit read wrong");
    a_evict: assert property (p_evict) else $error("flag not set after evict");
    a_flag_src: assert property (p_flag_src) else $error("flag without evict");
    a_irq_set: assert property (p_irq_set) else $error("irq missing");
    a_irq_src: assert property (p_irq_src) else $error("irq without tick");
    a_irq_fall: assert property (p_irq_fall) else $error("irq stuck");
    a_rst_start: assert property (p_rst_start) else $error("reset pulses wrong");
    a_rst_clr: assert property (p_rst_clr) else $error("reset left state");
    a_rst_len: assert property (p_rst_len) else $error("reset length wrong");
    a_run: assert property (p_run) else $error("halted while running");
    c_rst: cover property ($rose(ctrl_reset_active));
    c_flag: cover property ($rose(async_advance_flag));
    c_irq: cover property ($rose(async_advance_irq));
endmodule // uhcc_chk

bind uhcc_command uhcc_chk chk_u (.mclk, .rst_b, .reg_addr, .reg_rd, .reg_rdata, .reg_rvalid,
    .async_evict_done, .async_advance_int_en, .int_threshold_tick, .async_advance_flag_clr,
    .run_stop, .halted_flag,
    .async_evict_req, .async_advance_flag, .async_advance_irq, .ctrl_reset_active,
    .txn_abort, .port_owner_revert);

// ===== bench/usb_host_command_control_bench.sv
// Self-checking bench for the USB command register block
module usb_host_command_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import uhcc_pkg::*;
    logic        mclk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        prog_frame_list_flag = 1'b1, async_evict_done = 1'b0, txn_busy = 1'b0;
    logic        async_advance_int_en = 1'b0, int_threshold_tick = 1'b0;
    logic        async_advance_flag_clr = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [13:0] frame_index = 14'h2AAA;
    logic [9:0]  frame_list_index;
    logic        reg_rvalid, async_sched_enable, periodic_sched_enable, run_stop, halted_flag;
    logic        async_evict_req, async_advance_flag, async_advance_irq, ctrl_reset_active;
    logic        txn_abort, port_owner_revert;
    int          error_cnt = 0;
    int          num_checks = 0;
    uhcc_command dut_u (.mclk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .reg_rvalid, .prog_frame_list_flag, .async_evict_done, .txn_busy, .frame_index,
        .async_advance_int_en, .int_threshold_tick, .async_advance_flag_clr,
        .async_sched_enable, .periodic_sched_enable, .run_stop, .halted_flag,
        .async_evict_req, .async_advance_flag, .async_advance_irq, .frame_list_index,
        .ctrl_reset_active, .txn_abort, .port_owner_revert);
    always #20 mclk = ~mclk;
    task automatic report_and_stop;
        if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
            error_cnt++;
        end
    endtask
    // Inputs move 2 ns after the edge so sampling never races the drive
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        step(1);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        step(1);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        step(1);
        reg_addr = a;
        reg_rd = 1'b1;
        step(1);
        reg_rd = 1'b0;
        chk("rvalid", 32'h1, reg_rvalid);
        chk("rdata", exp, reg_rdata);
    endtask
    task automatic t_reset;
        rd(8'h20, 32'h0);
        wr(8'h24, 32'h1);
        rd(8'h24, 32'h0);
        chk("halted", 32'h1, halted_flag);
    endtask
    task automatic t_run;
        wr(8'h20, 32'h35);
        rd(8'h20, 32'h35);
        chk("enables", 32'h3, {async_sched_enable, periodic_sched_enable});
        chk("halted", 32'h0, halted_flag);
        chk("run_stop", 32'h1, run_stop);
        txn_busy = 1'b1;
        wr(8'h20, 32'h30);
        step(2);
        chk("halted", 32'h0, halted_flag);
        txn_busy = 1'b0;
        step(2);
        chk("halted", 32'h1, halted_flag);
        chk("run_stop", 32'h0, run_stop);
    endtask
    task automatic t_fls;
        int k;
        for (int c = 0; c < 4; c++) begin
            k = (c == 3) ? 2 : c;
            wr(8'h20, 32'h30 | (c << 2));
            rd(8'h20, 32'h30 | (k << 2));
            chk("fli", (14'h2AAA >> 3) & ((1024 >> k) - 1), frame_list_index);
        end
        prog_frame_list_flag = 1'b0;
        wr(8'h20, 32'h30);
        rd(8'h20, 32'h38);
    endtask
    task automatic t_bell(input logic en);
        async_advance_int_en = en;
        wr(8'h20, 32'h78);
        chk("evict_req", 32'h1, async_evict_req);
        rd(8'h20, 32'h78);
        async_evict_done = 1'b1;
        step(1);
        async_evict_done = 1'b0;
        chk("flag_req", 32'h1, {async_evict_req, async_advance_flag});
        rd(8'h20, 32'h38);
        int_threshold_tick = 1'b1;
        step(1);
        int_threshold_tick = 1'b0;
        chk("irq", {31'h0, en}, async_advance_irq);
        async_advance_flag_clr = 1'b1;
        step(1);
        async_advance_flag_clr = 1'b0;
        step(1);
        chk("irq", 32'h0, async_advance_irq);
    endtask
    task automatic t_hcr;
        time t0;
        int n;
        chk("halted", 32'h1, halted_flag);
        wr(8'h20, 32'h78);
        async_evict_done = 1'b1;
        step(1);
        async_evict_done = 1'b0;
        chk("flag", 32'h1, async_advance_flag);
        wr(8'h20, 32'h32);
        t0 = $time;
        chk("pulses", 32'h7, {ctrl_reset_active, txn_abort, port_owner_revert});
        chk("flag", 32'h0, async_advance_flag);
        chk("halted", 32'h1, halted_flag);
        chk("enables", 32'h0, {async_sched_enable, periodic_sched_enable});
        wr(8'h20, 32'h1);
        rd(8'h20, 32'h2);
        n = 0;
        while (ctrl_reset_active === 1'b1 && n < 200) begin
            step(1);
            n++;
        end
        chk("reset_len", RESET_CYCLES, ($time - t0) / 40);
        rd(8'h20, 32'h0);
    endtask
    initial begin
        step(4);
        rst_b = 1'b1;
        t_reset;
        t_run;
        t_fls;
        t_bell(1'b1);
        t_bell(1'b0);
        t_hcr;
        report_and_stop;
    end
    // Whole sequence needs well under 400 cycles
    initial begin
        #100000;
        error_cnt++;
        report_and_stop;
    end
endmodule // usb_host_command_control_bench

// ===== rtl/uhcc_command.sv
// Module: USB command register with doorbell, schedule enables and reset control
module uhcc_command (
    input  wire logic                          mclk,
    input  wire logic                          rst_b,
    input  wire logic [uhcc_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    input  wire logic [uhcc_pkg::DATA_W-1:0]   reg_wdata,
    output logic      [uhcc_pkg::DATA_W-1:0]   reg_rdata,
    output logic                               reg_rvalid,
    input  wire logic                          prog_frame_list_flag,
    input  wire logic                          async_evict_done,
    input  wire logic                          txn_busy,
    input  wire logic [uhcc_pkg::FRINDEX_W-1:0] frame_index,
    input  wire logic                          async_advance_int_en,
    input  wire logic                          int_threshold_tick,
    input  wire logic                          async_advance_flag_clr,
    output logic                               async_sched_enable,
    output logic                               periodic_sched_enable,
    output logic                               run_stop,
    output logic                               halted_flag,
    output logic                               async_evict_req,
    output logic                               async_advance_flag,
    output logic                               async_advance_irq,
    output logic      [uhcc_pkg::FL_INDEX_W-1:0] frame_list_index,
    output logic                               ctrl_reset_active,
    output logic                               txn_abort,
    output logic                               port_owner_revert
);
    import uhcc_pkg::*;

    logic                  rs_reg;
    logic                  rs_next;
    logic                  ase_reg;
    logic                  ase_next;
    logic                  pse_reg;
    logic                  pse_next;
    logic [1:0]            fls_reg;
    logic [1:0]            fls_next;
    uhcc_db_state_t        db_reg;
    uhcc_db_state_t        db_next;
    logic                  flag_reg;
    logic                  flag_next;
    logic                  irq_reg;
    logic                  irq_next;
    logic                  halt_reg;
    logic                  halt_next;
    logic                  abort_reg;
    logic                  abort_next;
    logic                  revert_reg;
    logic                  revert_next;
    logic [FL_INDEX_W-1:0] idx_reg;
    logic [FL_INDEX_W-1:0] idx_next;
    logic [DATA_W-1:0]     rdata_reg;
    logic [DATA_W-1:0]     rdata_next;
    logic                  rvalid_reg;
    logic                  rvalid_next;

    logic                  cmd_wr;
    logic                  rst_start;
    logic                  rst_busy;
    logic [DATA_W-1:0]     cmd_value;

    assign cmd_wr    = reg_wr && (reg_addr == USB_COMMAND_OFS);
    // Only a halted-agnostic trigger; software is trusted to check halt first
    assign rst_start = cmd_wr && reg_wdata[CTRL_RESET_BIT] && !rst_busy;

    // Reset length is fixed; a zero write cannot shorten it
    uhcc_timer #(
        .CYCLES (RESET_CYCLES)
    ) u_reset_timer (
        .mclk  (mclk),
        .rst_b (rst_b),
        .start (rst_start),
        .busy  (rst_busy),
        .done  ()
    );

    // Live readback; the reset bit reads one until the timer ends, the doorbell bit until the cycle after async_evict_done
    always_comb begin
        cmd_value                 = USB_COMMAND_RST;
        cmd_value[RUN_STOP_BIT]   = rs_reg;
        cmd_value[CTRL_RESET_BIT] = rst_busy;
        cmd_value[FLS_LSB +: 2]   = fls_reg;
        cmd_value[PSE_BIT]        = pse_reg;
        cmd_value[ASE_BIT]        = ase_reg;
        cmd_value[DOORBELL_BIT]   = (db_reg != UHCC_DB_IDLE);
    end

    always_comb begin
        rs_next     = rs_reg;
        ase_next    = ase_reg;
        pse_next    = pse_reg;
        fls_next    = fls_reg;
        db_next     = db_reg;
        flag_next   = flag_reg;
        irq_next    = irq_reg;
        if (cmd_wr && !rst_busy && !rst_start) begin
            rs_next  = reg_wdata[RUN_STOP_BIT];
            ase_next = reg_wdata[ASE_BIT];
            pse_next = reg_wdata[PSE_BIT];
            // Reserved size code is dropped so the index mapping stays defined
            if (prog_frame_list_flag &&
                (reg_wdata[FLS_LSB +: 2] != UHCC_FLS_RSVD)) begin
                fls_next = reg_wdata[FLS_LSB +: 2];
            end
        end

        unique case (db_reg)
            UHCC_DB_IDLE: begin
                if (cmd_wr && reg_wdata[DOORBELL_BIT] && !rst_busy) begin
                    db_next = UHCC_DB_EVICT;
                end
            end
            UHCC_DB_EVICT: begin
                if (async_evict_done) begin
                    flag_next = 1'b1;
                    db_next   = UHCC_DB_CLEAR;
                end
            end
            UHCC_DB_CLEAR: begin
                db_next = UHCC_DB_IDLE;
            end
            default: db_next = UHCC_DB_IDLE;
        endcase

        // Set beats clear in the same cycle
        if (async_advance_flag_clr && !(db_reg == UHCC_DB_EVICT && async_evict_done)) begin
            flag_next = 1'b0;
        end

        if (!flag_next) begin
            irq_next = 1'b0;
        end else if (int_threshold_tick && async_advance_int_en) begin
            irq_next = 1'b1;
        end

        // Held at initial values for the whole reset; a zero write is ignored
        if (rst_start || rst_busy) begin
            rs_next   = 1'b0;
            ase_next  = 1'b0;
            pse_next  = 1'b0;
            fls_next  = UHCC_FLS_1024;
            db_next   = UHCC_DB_IDLE;
            flag_next = 1'b0;
            irq_next  = 1'b0;
        end
    end

    // Halted once run_stop is clear and the transaction in flight has drained, or at once during a controller reset
    always_comb begin
        abort_next  = rst_start;
        revert_next = rst_start;
        halt_next   = (!rs_reg && !txn_busy) || rst_start || rst_busy;
    end

    always_comb begin
        idx_next = '0;
        unique case (uhcc_fls_t'(fls_reg))
            UHCC_FLS_1024: idx_next = frame_index[FRINDEX_LSB +: FL_INDEX_W];
            // Upper index bits stay zero for the shorter lists
            UHCC_FLS_512:  idx_next = {1'b0, frame_index[FRINDEX_LSB +: FL_INDEX_W-1]};
            UHCC_FLS_256,
            UHCC_FLS_RSVD: idx_next = {2'h0, frame_index[FRINDEX_LSB +: FL_INDEX_W-2]};
        endcase
    end

    // Zero outside a read so a stale word never lingers on the bus
    always_comb begin
        rvalid_next = reg_rd;
        rdata_next  = '0;
        if (reg_rd && (reg_addr == USB_COMMAND_OFS)) begin
            rdata_next = cmd_value;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rs_reg     <= 1'b0;
            ase_reg    <= 1'b0;
            pse_reg    <= 1'b0;
            fls_reg    <= UHCC_FLS_1024;
            db_reg     <= UHCC_DB_IDLE;
            flag_reg   <= 1'b0;
            irq_reg    <= 1'b0;
            halt_reg   <= 1'b1;
            abort_reg  <= 1'b0;
            revert_reg <= 1'b0;
        end else begin
            rs_reg     <= rs_next;
            ase_reg    <= ase_next;
            pse_reg    <= pse_next;
            fls_reg    <= fls_next;
            db_reg     <= db_next;
            flag_reg   <= flag_next;
            irq_reg    <= irq_next;
            halt_reg   <= halt_next;
            abort_reg  <= abort_next;
            revert_reg <= revert_next;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            idx_reg    <= '0;
            rdata_reg  <= '0;
            rvalid_reg <= 1'b0;
        end else begin
            idx_reg    <= idx_next;
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign reg_rdata             = rdata_reg;
    assign reg_rvalid            = rvalid_reg;
    assign run_stop              = rs_reg;
    assign async_sched_enable    = ase_reg;
    assign periodic_sched_enable = pse_reg;
    assign halted_flag           = halt_reg;
    assign async_evict_req       = (db_reg == UHCC_DB_EVICT);
    assign async_advance_flag    = flag_reg;
    assign async_advance_irq     = irq_reg;
    assign frame_list_index      = idx_reg;
    assign ctrl_reset_active     = rst_busy;
    assign txn_abort             = abort_reg;
    assign port_owner_revert     = revert_reg;
endmodule // uhcc_command

// ===== rtl/uhcc_pkg.sv
// Package: constants and types for the USB host command register block
package uhcc_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam logic [7:0]  USB_COMMAND_OFS = 8'h20;
    localparam logic [31:0] USB_COMMAND_RST = 32'h0000_0000;
    localparam int          RUN_STOP_BIT    = 0;
    localparam int          CTRL_RESET_BIT  = 1;
    localparam int          FLS_LSB         = 2;
    localparam int          PSE_BIT         = 4;
    localparam int          ASE_BIT         = 5;
    localparam int          DOORBELL_BIT    = 6;
    localparam int          FRINDEX_W       = 14;
    localparam int          FRINDEX_LSB     = 3;
    localparam int          FL_INDEX_W      = 10;
    localparam int          CLK_PERIOD_NS   = 40;
    localparam int          RESET_TIME_NS   = 2000;
    localparam int          RESET_CYCLES    =
        (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        UHCC_FLS_1024 = 2'h0,
        UHCC_FLS_512  = 2'h1,
        UHCC_FLS_256  = 2'h2,
        UHCC_FLS_RSVD = 2'h3
    } uhcc_fls_t;

    typedef enum logic [1:0] {
        UHCC_DB_IDLE,
        UHCC_DB_EVICT,
        UHCC_DB_CLEAR
    } uhcc_db_state_t;
endpackage

// ===== rtl/uhcc_timer.sv
// Module: one-shot cycle timer used to stretch the controller reset
module uhcc_timer #(
    parameter int CYCLES = 50
) (
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic          busy_reg;
    logic          busy_next;
    logic          done_reg;
    logic          done_next;

    always_comb begin
        count_next = count_reg;
        busy_next  = busy_reg;
        done_next  = 1'b0;
        if (busy_reg) begin
            if (count_reg == LAST) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end else begin
                count_next = count_reg + CW'(1);
            end
        end else if (start) begin
            busy_next  = 1'b1;
            count_next = '0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= '0;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            count_reg <= count_next;
            busy_reg  <= busy_next;
            done_reg  <= done_next;
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;
endmodule // uhcc_timer
